// [fsic_chk.sv]
// Concurrent checks on the ports of the buffer status and IRQ block
`timescale 1ns/1ps
module fsic_chk #(
   parameter int LINES = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ioAddr,
   input wire logic [7:0] ioWrData,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioRdData,
   input wire logic convDone,
   input wire logic sampleStore,
   input wire logic adcIrqReq,
   input wire logic ctr1Out,
   input wire logic [LINES-1:0] generalIoLines,
   input wire logic [LINES-1:0] optoLines,
   input wire logic irqLineOut,
   input wire logic irqLineOe,
   input wire logic pageSelect,
   input wire logic bufferThresholdSelect,
   input wire logic bufferIrqMode,
   input wire logic scanModeOn,
   input wire logic [LINES-1:0] gpioEdgeStatus
);
   import fsic_pkg::*;
   // All checks run on the one clock and sleep through reset
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_irq_line_level: assert property (irqLineOe |-> irqLineOut)
      else $error("irq line driven low");
   a_irq_held_pending: assert property (irqLineOe && !(ioWrite && ioAddr == OFS_IRQ) |=> irqLineOe)
      else $error("irq dropped without a write");
   a_disable_releases: assert property (ioWrite && ioAddr == OFS_IRQ && ioWrData[3:0] == 4'h0 |=> !irqLineOe)
      else $error("irq kept with all enables off");
   a_ack_all_clears: assert property (!adcIrqReq && !$fell(ctr1Out) &&
      $stable(generalIoLines) && $stable(optoLines) && ioWrite && ioAddr == OFS_IRQ && ioWrData[7:4] == 4'hf
      |=> !irqLineOe)
      else $error("irq kept after full ack");
   a_mode_echo: assert property (ioWrite && ioAddr == OFS_BUF |=>
      {pageSelect, bufferThresholdSelect, bufferIrqMode, scanModeOn} == $past(ioWrData[3:0]))
      else $error("mode bits differ from write");
   a_gpio_edge_seen: assert property (!$stable(generalIoLines) |=>
      (gpioEdgeStatus | ~($past(generalIoLines) ^ $past(generalIoLines, 2))) == '1)
      else $error("line change not recorded");
   a_store_needs_conv: assert property (sampleStore |-> convDone)
      else $error("store without conversion");
   a_flush_empties: assert property ((ioWrite && ioAddr == OFS_COMMAND && ioWrData[CMD_FLUSH_BIT])
      ##1 !convDone ##1 (ioRead && ioAddr == OFS_BUF) |=> ioRdData[7:4] == 4'h1)
      else $error("buffer flags wrong after flush");

   // Main scenarios reached
   c_irq_release: cover property (irqLineOe ##1 !irqLineOe);
   c_conv_dropped: cover property (convDone && !sampleStore);
   c_irq_read: cover property (ioRead && ioAddr == OFS_IRQ);
endmodule : fsic_chk

bind fsic_top fsic_chk #(.LINES(LINES)) chk (.clk, .rst, .ioAddr, .ioWrData, .ioWrite, .ioRead, .ioRdData,
   .convDone, .sampleStore, .adcIrqReq, .ctr1Out, .generalIoLines, .optoLines, .irqLineOut, .irqLineOe,
   .pageSelect, .bufferThresholdSelect, .bufferIrqMode, .scanModeOn, .gpioEdgeStatus);

// [fsic_fill_tracker.sv]
// Sample buffer occupancy counter with overrun and flush handling
`timescale 1ns/1ps
module fsic_fill_tracker #(
   parameter int DEPTH = fsic_pkg::BUF_DEPTH,
   parameter int CW = $clog2(fsic_pkg::BUF_DEPTH) + 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic convDone,
   input wire logic sampleTaken,
   input wire logic flush,
   output logic sampleStore,
   output logic [CW-1:0] fillCount,
   output logic bufferOverrunFlag,
   output logic bufferFullFlag,
   output logic bufferEmptyFlag
);
   import fsic_pkg::*;

   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [CW-1:0] ZERO_COUNT = '0;

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic overrun_r;
   logic overrun_nxt;
   logic take;

   assign bufferFullFlag = (count_r == FULL_COUNT);
   assign bufferEmptyFlag = (count_r == ZERO_COUNT);
   assign take = sampleTaken && !bufferEmptyFlag;
   // keep contents when overrun
   // A read in the same cycle frees a slot, so full plus read still stores
   assign sampleStore = convDone && !overrun_r && !flush && (!bufferFullFlag || take);

   // Occupancy and overrun next state
   always_comb begin
      count_nxt = count_r;
      overrun_nxt = overrun_r;
      if (flush) begin
         count_nxt = ZERO_COUNT;
         overrun_nxt = 1'b0;
      end else begin
         if (sampleStore && !take) begin
            count_nxt = count_r + CW'(1);
         end else if (take && !sampleStore) begin
            count_nxt = count_r - CW'(1);
         end
         if (convDone && bufferFullFlag && !take) begin
            overrun_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= ZERO_COUNT;
         overrun_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         overrun_r <= overrun_nxt;
      end
   end

   assign fillCount = count_r;
   assign bufferOverrunFlag = overrun_r;
endmodule : fsic_fill_tracker

// [fsic_host.sv]
// Host bus model issuing byte reads and writes to the block
`timescale 1ns/1ps
module fsic_host (
   input wire logic clk,
   input wire logic [7:0] ioRdData,
   output logic [3:0] ioAddr,
   output logic [7:0] ioWrData,
   output logic ioWrite,
   output logic ioRead
);
   // Bus idle from time zero
   initial begin
      ioAddr = 4'h0;
      ioWrData = 8'h00;
      ioWrite = 1'b0;
      ioRead = 1'b0;
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk);
      ioAddr = a;
      ioWrData = d;
      ioWrite = 1'b1;
      @(negedge clk);
      ioWrite = 1'b0;
   endtask : wr

   // Read data is registered, so it is settled by the next falling edge
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(negedge clk);
      ioAddr = a;
      ioRead = 1'b1;
      @(negedge clk);
      ioRead = 1'b0;
      d = ioRdData;
   endtask : rd
endmodule : fsic_host

// [fsic_pkg.sv]
// Package of offsets, field positions, reset values and levels for the FIFO status and IRQ block
package fsic_pkg;
   // Register offsets on the byte-wide expansion bus
   localparam logic [3:0] OFS_OPTO_CFG = 4'h6;
   localparam logic [3:0] OFS_COMMAND = 4'h8;
   localparam logic [3:0] OFS_IRQ = 4'h9;
   localparam logic [3:0] OFS_BUF = 4'ha;
   // Command register
   localparam int CMD_FLUSH_BIT = 4;
   // Buffer status fields
   localparam int BUF_OVERRUN_BIT = 7;
   localparam int BUF_HALF_BIT = 6;
   localparam int BUF_EIGHTH_BIT = 5;
   localparam int BUF_EMPTY_BIT = 4;
   localparam int BUF_PAGE_BIT = 3;
   localparam int BUF_THRESH_BIT = 2;
   localparam int BUF_IRQMODE_BIT = 1;
   localparam int BUF_SCAN_BIT = 0;
   // IRQ control / status fields
   localparam int IRQ_TIMER_ACK_BIT = 7;
   localparam int IRQ_GPIO_ACK_BIT = 6;
   localparam int IRQ_OPTO_ACK_BIT = 5;
   localparam int IRQ_ADC_ACK_BIT = 4;
   localparam int IRQ_TIMER_EN_BIT = 3;
   localparam int IRQ_GPIO_EN_BIT = 2;
   localparam int IRQ_OPTO_EN_BIT = 1;
   localparam int IRQ_ADC_EN_BIT = 0;
   // Opto config: low nibble edge enables, high nibble polarity (1 = rising)
   localparam int OPTO_POL_LSB = 4;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_NIB = 4'h0;
   // Buffer levels in samples, and number of I/O lines
   localparam int BUF_DEPTH = 2048;
   localparam int LEVEL_EIGHTH = 256;
   localparam int LEVEL_HALF = 1024;
   localparam int LINE_COUNT = 4;
endpackage : fsic_pkg

// [fsic_top.sv]
// Buffer status register, per-source interrupt flip-flops and shared IRQ line driver
`timescale 1ns/1ps
module fsic_top #(
   parameter int DEPTH = fsic_pkg::BUF_DEPTH,
   parameter int LINES = fsic_pkg::LINE_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ioAddr,
   input wire logic [7:0] ioWrData,
   input wire logic ioWrite,
   input wire logic ioRead,
   output logic [7:0] ioRdData,
   input wire logic convDone,
   input wire logic sampleTaken,
   output logic sampleStore,
   input wire logic adcIrqReq,
   input wire logic ctr1Out,
   input wire logic [LINES-1:0] generalIoLines,
   input wire logic [LINES-1:0] optoLines,
   output logic irqLineOut,
   output logic irqLineOe,
   output logic pageSelect,
   output logic bufferThresholdSelect,
   output logic bufferIrqMode,
   output logic scanModeOn,
   output logic thresholdReached,
   output logic [LINES-1:0] gpioEdgeStatus,
   output logic [LINES-1:0] optoEdgeStatus
);
   import fsic_pkg::*;

   localparam int CW = $clog2(DEPTH) + 1;

   // Count compare used for both level flags and the threshold
   function automatic logic atLeast(input logic [CW-1:0] cnt, input int level);
      atLeast = (cnt >= CW'(level));
   endfunction : atLeast

   // Decoded bus strobes
   logic wrCmd;
   logic wrIrq;
   logic wrBuf;
   logic wrOpto;
   logic flush;

   // Tracker outputs and level flags
   logic [CW-1:0] fillCount;
   logic bufferOverrunFlag;
   logic bufferFullFlag;
   logic bufferEmptyFlag;
   logic bufferHalfLevelFlag;
   logic bufferEighthLevelFlag;

   // Configuration state
   logic [3:0] mode_r;
   logic [3:0] mode_nxt;
   logic [3:0] irqEnable_r;
   logic [3:0] irqEnable_nxt;
   logic [LINES-1:0] optoEdgeEnables_r;
   logic [LINES-1:0] optoEdgeEnables_nxt;
   logic [LINES-1:0] optoEdgePolarity_r;
   logic [LINES-1:0] optoEdgePolarity_nxt;

   // Interrupt state
   logic timerIrqPending_r;
   logic timerIrqPending_nxt;
   logic gpioIrqPending_r;
   logic gpioIrqPending_nxt;
   logic optoIrqPending_r;
   logic optoIrqPending_nxt;
   logic adcIrqPending_r;
   logic adcIrqPending_nxt;
   logic [LINES-1:0] gpioEdge_r;
   logic [LINES-1:0] gpioEdge_nxt;
   logic [LINES-1:0] optoEdge_r;
   logic [LINES-1:0] optoEdge_nxt;

   // Input history for edge detection
   logic ctr1Prev_r;
   logic [LINES-1:0] gpioPrev_r;
   logic [LINES-1:0] optoPrev_r;

   // Event terms
   logic timerReq;
   logic gpioReq;
   logic optoReq;
   logic adcReq;
   logic [LINES-1:0] gpioChange;
   logic [LINES-1:0] optoHit;
   logic timerAck;
   logic gpioAck;
   logic optoAck;
   logic adcAck;

   // Read data
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic [7:0] bufStatus;
   logic [7:0] irqStatus;

   // Bus decode; writes are single-cycle strobes
   assign wrCmd = ioWrite && (ioAddr == OFS_COMMAND);
   assign wrIrq = ioWrite && (ioAddr == OFS_IRQ);
   assign wrBuf = ioWrite && (ioAddr == OFS_BUF);
   assign wrOpto = ioWrite && (ioAddr == OFS_OPTO_CFG);
   assign flush = wrCmd && ioWrData[CMD_FLUSH_BIT];

   fsic_fill_tracker #(
      .DEPTH(DEPTH),
      .CW(CW)
   ) fillTracker (
      .clk(clk),
      .rst(rst),
      .convDone(convDone),
      .sampleTaken(sampleTaken),
      .flush(flush),
      .sampleStore(sampleStore),
      .fillCount(fillCount),
      .bufferOverrunFlag(bufferOverrunFlag),
      .bufferFullFlag(bufferFullFlag),
      .bufferEmptyFlag(bufferEmptyFlag)
   );

   assign bufferEighthLevelFlag = atLeast(fillCount, LEVEL_EIGHTH);
   assign bufferHalfLevelFlag = atLeast(fillCount, LEVEL_HALF);
   assign thresholdReached = mode_r[BUF_THRESH_BIT] ? bufferEighthLevelFlag : bufferHalfLevelFlag;

   // Ack strobes; a zero bit leaves its flag alone
   // only ones clear
   assign timerAck = wrIrq && ioWrData[IRQ_TIMER_ACK_BIT];
   assign gpioAck = wrIrq && ioWrData[IRQ_GPIO_ACK_BIT];
   assign optoAck = wrIrq && ioWrData[IRQ_OPTO_ACK_BIT];
   assign adcAck = wrIrq && ioWrData[IRQ_ADC_ACK_BIT];

   // Source requests, each gated by its enable
   // timer falling edge
   assign timerReq = irqEnable_r[IRQ_TIMER_EN_BIT] && ctr1Prev_r && !ctr1Out;
   assign gpioChange = generalIoLines ^ gpioPrev_r;
   assign gpioReq = irqEnable_r[IRQ_GPIO_EN_BIT] && (|gpioChange);
   assign optoHit = optoEdgeEnables_r &
      ((optoEdgePolarity_r & optoLines & ~optoPrev_r) | (~optoEdgePolarity_r & ~optoLines & optoPrev_r));
   assign optoReq = irqEnable_r[IRQ_OPTO_EN_BIT] && (|optoHit);
   assign adcReq = irqEnable_r[IRQ_ADC_EN_BIT] && adcIrqReq;

   // Configuration next values
   always_comb begin
      mode_nxt = mode_r;
      irqEnable_nxt = irqEnable_r;
      optoEdgeEnables_nxt = optoEdgeEnables_r;
      optoEdgePolarity_nxt = optoEdgePolarity_r;
      if (wrBuf) begin
         mode_nxt = ioWrData[3:0];
      end
      if (wrIrq) begin
         // Enables are always written with the ack bits
         irqEnable_nxt = ioWrData[3:0];
      end
      if (wrOpto) begin
         optoEdgeEnables_nxt = ioWrData[LINES-1:0];
         optoEdgePolarity_nxt = ioWrData[OPTO_POL_LSB +: LINES];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode_r <= RST_NIB;
         irqEnable_r <= RST_NIB;
         optoEdgeEnables_r <= '0;
         optoEdgePolarity_r <= '0;
      end else begin
         mode_r <= mode_nxt;
         irqEnable_r <= irqEnable_nxt;
         optoEdgeEnables_r <= optoEdgeEnables_nxt;
         optoEdgePolarity_r <= optoEdgePolarity_nxt;
      end
   end

   // Interrupt flip-flops; a request in the ack cycle wins so no event is lost
   always_comb begin
      timerIrqPending_nxt = timerIrqPending_r;
      gpioIrqPending_nxt = gpioIrqPending_r;
      optoIrqPending_nxt = optoIrqPending_r;
      adcIrqPending_nxt = adcIrqPending_r;
      gpioEdge_nxt = gpioEdge_r;
      optoEdge_nxt = optoEdge_r;
      if (timerAck) begin
         timerIrqPending_nxt = 1'b0;
      end
      if (gpioAck) begin
         gpioIrqPending_nxt = 1'b0;
         gpioEdge_nxt = '0;
      end
      if (optoAck) begin
         optoIrqPending_nxt = 1'b0;
         optoEdge_nxt = '0;
      end
      if (adcAck) begin
         adcIrqPending_nxt = 1'b0;
      end
      // Edge status keeps recording even with the source interrupt disabled
      gpioEdge_nxt = gpioEdge_nxt | gpioChange;
      optoEdge_nxt = optoEdge_nxt | optoHit;
      if (timerReq) begin
         timerIrqPending_nxt = 1'b1;
      end
      if (gpioReq) begin
         gpioIrqPending_nxt = 1'b1;
      end
      if (optoReq) begin
         optoIrqPending_nxt = 1'b1;
      end
      if (adcReq) begin
         adcIrqPending_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         timerIrqPending_r <= 1'b0;
         gpioIrqPending_r <= 1'b0;
         optoIrqPending_r <= 1'b0;
         adcIrqPending_r <= 1'b0;
         gpioEdge_r <= '0;
         optoEdge_r <= '0;
         ctr1Prev_r <= 1'b0;
         gpioPrev_r <= '0;
         optoPrev_r <= '0;
      end else begin
         timerIrqPending_r <= timerIrqPending_nxt;
         gpioIrqPending_r <= gpioIrqPending_nxt;
         optoIrqPending_r <= optoIrqPending_nxt;
         adcIrqPending_r <= adcIrqPending_nxt;
         gpioEdge_r <= gpioEdge_nxt;
         optoEdge_r <= optoEdge_nxt;
         ctr1Prev_r <= ctr1Out;
         gpioPrev_r <= generalIoLines;
         optoPrev_r <= optoLines;
      end
   end

   // Shared IRQ line: driven high while any enabled flag is pending, else floated
   // drive on pending
   assign irqLineOe = (timerIrqPending_r && irqEnable_r[IRQ_TIMER_EN_BIT]) ||
      (gpioIrqPending_r && irqEnable_r[IRQ_GPIO_EN_BIT]) ||
      (optoIrqPending_r && irqEnable_r[IRQ_OPTO_EN_BIT]) ||
      (adcIrqPending_r && irqEnable_r[IRQ_ADC_EN_BIT]);
   assign irqLineOut = irqLineOe;

   // Status bytes
   always_comb begin
      bufStatus = RST_BYTE;
      bufStatus[BUF_OVERRUN_BIT] = bufferOverrunFlag;
      bufStatus[BUF_HALF_BIT] = bufferHalfLevelFlag;
      bufStatus[BUF_EIGHTH_BIT] = bufferEighthLevelFlag;
      bufStatus[BUF_EMPTY_BIT] = bufferEmptyFlag;
      bufStatus[3:0] = mode_r;
      irqStatus = RST_BYTE;
      irqStatus[IRQ_TIMER_ACK_BIT] = timerIrqPending_r;
      irqStatus[IRQ_GPIO_ACK_BIT] = gpioIrqPending_r;
      irqStatus[IRQ_OPTO_ACK_BIT] = optoIrqPending_r;
      irqStatus[IRQ_ADC_ACK_BIT] = adcIrqPending_r;
      irqStatus[3:0] = irqEnable_r;
   end

   // Read data is captured on the read strobe and held until the next read
   always_comb begin
      rdData_nxt = rdData_r;
      if (ioRead) begin
         unique case (ioAddr)
            OFS_BUF: begin
               rdData_nxt = bufStatus;
            end
            OFS_IRQ: begin
               rdData_nxt = irqStatus;
            end
            default: begin
               rdData_nxt = RST_BYTE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_r <= RST_BYTE;
      end else begin
         rdData_r <= rdData_nxt;
      end
   end

   assign ioRdData = rdData_r;
   assign pageSelect = mode_r[BUF_PAGE_BIT];
   assign bufferThresholdSelect = mode_r[BUF_THRESH_BIT];
   assign bufferIrqMode = mode_r[BUF_IRQMODE_BIT];
   assign scanModeOn = mode_r[BUF_SCAN_BIT];
   assign gpioEdgeStatus = gpioEdge_r;
   assign optoEdgeStatus = optoEdge_r;
endmodule : fsic_top

// [tb.sv]
// Self-checking testbench for the buffer status and IRQ block
`timescale 1ns/1ps
module tb;
   import fsic_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic convDone = 1'b0;
   logic sampleTaken = 1'b0;
   logic adcIrqReq = 1'b0;
   logic ctr1Out = 1'b0;
   logic [3:0] generalIoLines = 4'h0;
   logic [3:0] optoLines = 4'h0;
   logic [3:0] ioAddr;
   logic [7:0] ioWrData;
   logic [7:0] ioRdData;
   logic ioWrite;
   logic ioRead;
   logic sampleStore;
   logic irqLineOut;
   logic irqLineOe;
   logic thresholdReached;
   logic [3:0] gpioEdgeStatus;
   logic [3:0] optoEdgeStatus;
   int failures = 0;
   int checkCount = 0;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   fsic_host host (.clk, .ioRdData, .ioAddr, .ioWrData, .ioWrite, .ioRead);
   fsic_top dut (.clk, .rst, .ioAddr, .ioWrData, .ioWrite, .ioRead, .ioRdData, .convDone, .sampleTaken,
      .sampleStore, .adcIrqReq, .ctr1Out, .generalIoLines, .optoLines, .irqLineOut, .irqLineOe, .pageSelect(),
      .bufferThresholdSelect(), .bufferIrqMode(), .scanModeOn(), .thresholdReached, .gpioEdgeStatus,
      .optoEdgeStatus);

   // Compare and count
   task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checkCount++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk

   // Read a register and compare
   task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(a, v);
      chk(n, v, exp);
   endtask : rchk

   // Back-to-back conversions, one per cycle
   task automatic conv(input int n);
      repeat (n) begin
         @(negedge clk);
         convDone = 1'b1;
      end
      @(negedge clk);
      convDone = 1'b0;
   endtask : conv

   // One conversion with its store strobe looked at in the same cycle
   task automatic convChk(input logic expStore);
      @(negedge clk);
      convDone = 1'b1;
      #1 chk("sampleStore", {7'h0, sampleStore}, {7'h0, expStore});
      @(negedge clk);
      convDone = 1'b0;
   endtask : convChk

   // Timer falling edge, line 0 toggles, one A/D request
   task automatic events();
      @(negedge clk);
      ctr1Out = 1'b1;
      @(negedge clk);
      ctr1Out = 1'b0;
      generalIoLines = generalIoLines ^ 4'h1;
      optoLines = optoLines ^ 4'h1;
      adcIrqReq = 1'b1;
      @(negedge clk);
      adcIrqReq = 1'b0;
      @(negedge clk);
   endtask : events

   // Fill levels, overrun on a full buffer, then flush
   task automatic t_buffer();
      rchk("bufStatus", OFS_BUF, 8'h10);
      rchk("unmapped", 4'h0, 8'h00);
      host.wr(OFS_BUF, 8'h05);
      rchk("bufStatus", OFS_BUF, 8'h15);
      conv(256);
      rchk("bufStatus", OFS_BUF, 8'h25);
      chk("thrReached", {7'h0, thresholdReached}, 8'h01);
      host.wr(OFS_BUF, 8'h01);
      chk("thrReached", {7'h0, thresholdReached}, 8'h00);
      conv(768);
      rchk("bufStatus", OFS_BUF, 8'h61);
      chk("thrReached", {7'h0, thresholdReached}, 8'h01);
      conv(1024);
      rchk("bufStatus", OFS_BUF, 8'h61);
      convChk(1'b0);
      rchk("bufStatus", OFS_BUF, 8'he1);
      @(negedge clk);
      sampleTaken = 1'b1;
      @(negedge clk);
      sampleTaken = 1'b0;
      convChk(1'b0);
      rchk("bufStatus", OFS_BUF, 8'he1);
      host.wr(OFS_COMMAND, 8'h10);
      rchk("bufStatus", OFS_BUF, 8'h11);
      // Page and irq mode bits are otherwise never set
      host.wr(OFS_BUF, 8'h0a);
      rchk("bufStatus", OFS_BUF, 8'h1a);
      $display("t_buffer done");
   endtask : t_buffer

   // Sources disabled, then enabled, masked and acknowledged one by one
   task automatic t_irq();
      events();
      rchk("irqStatus", OFS_IRQ, 8'h00);
      chk("irqOe", {7'h0, irqLineOe}, 8'h00);
      host.wr(OFS_OPTO_CFG, 8'h01);
      host.wr(OFS_IRQ, 8'h0f);
      events();
      rchk("irqStatus", OFS_IRQ, 8'hff);
      chk("irqPin", {6'h0, irqLineOe, irqLineOut}, 8'h03);
      chk("gpioEdge", {4'h0, gpioEdgeStatus}, 8'h01);
      host.wr(OFS_IRQ, 8'h00);
      rchk("irqStatus", OFS_IRQ, 8'hf0);
      chk("irqOe", {7'h0, irqLineOe}, 8'h00);
      host.wr(OFS_IRQ, 8'h0f);
      chk("irqOe", {7'h0, irqLineOe}, 8'h01);
      host.wr(OFS_IRQ, 8'h8f);
      rchk("irqStatus", OFS_IRQ, 8'h7f);
      host.wr(OFS_IRQ, 8'h4f);
      rchk("irqStatus", OFS_IRQ, 8'h3f);
      chk("gpioEdge", {4'h0, gpioEdgeStatus}, 8'h00);
      host.wr(OFS_IRQ, 8'h2f);
      rchk("irqStatus", OFS_IRQ, 8'h1f);
      chk("optoEdge", {4'h0, optoEdgeStatus}, 8'h00);
      host.wr(OFS_IRQ, 8'hff);
      rchk("irqStatus", OFS_IRQ, 8'h0f);
      chk("irqOe", {7'h0, irqLineOe}, 8'h00);
      $display("t_irq done");
   endtask : t_irq

   // Verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   // Reset for three cycles, then the scenarios
   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_buffer();
      t_irq();
      wrap_up();
   end

   // Watchdog: the run needs about 2100 cycles, so 20000 is ample
   initial begin
      #100000;
      failures++;
      wrap_up();
   end
endmodule : tb
